/* dds_consts.svh */
// offsets, field positions and reset values of the synthesizer control block
// Functional notes
// - A write strobe high at a clock edge stores the value bus into the step or shift store of the addressed channel.
// - Accumulation and output run only while the run gate is high, yet store writes still land when it is low.
// - An N-bit value is a phase angle on a circle of 2^N segments, so signed and unsigned readings behave alike.
// - While the synchronous clear is high the accumulators and channel counter return to their start state.
// - The clear also drops output-valid, and the channel, sine, cosine and phase outputs mean nothing until it rises.
// - The clear leaves the step and shift stores intact, and a store write is accepted during the clear.
// - With the step streaming, the per-cycle step comes from the streaming step input.
// - With the shift streaming, the streaming shift input is added to the accumulated phase.
// - In lookup-only mode the phase generator is bypassed and the lookup phase input maps to sine and cosine.
// - Output-valid is high exactly when the presented samples are valid and low otherwise.
// - During a write the target select at 0 chooses the step store and at 1 the shift store.
// - The slot select picks one of up to 16 channels, 1 bit for 2, 2 for 3-4, 3 for 5-8 and 4 for 9-16.
// - The phase generator is an accumulator of the step followed by an optional adder of the shift.
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH

// ============================================================
// register offsets (byte addresses)
`define DDS_CFG_OFS 12'h000
`define DDS_STAT_OFS 12'h004
`define DDS_ADDR_W 12

// ============================================================
// configuration fields
`define DDS_CFG_STEP_SRC 0
`define DDS_CFG_SHIFT_SRC 1
`define DDS_CFG_LUT_ONLY 2
`define DDS_CFG_SHIFT_EN 3
`define DDS_CFG_W 4
`define DDS_CFG_RST 4'h8

// ============================================================
// status fields
`define DDS_STAT_VALID 0
`define DDS_STAT_CHAN_LSB 4

`endif

/* dds_pkg.sv */
// types shared by the synthesizer control block
package dds_pkg;
  typedef enum logic {
    DDS_SRC_STORE = 1'b0,
    DDS_SRC_STREAM = 1'b1
  } dds_src_e;
  typedef enum logic {
    DDS_TGT_STEP = 1'b0,
    DDS_TGT_SHIFT = 1'b1
  } dds_tgt_e;
endpackage

/* dds_chan_store.sv */
// per-channel phase step and phase shift stores with the write port
`timescale 1ns/1ps
`default_nettype none
module dds_chan_store #(
  parameter int N = 32,
  parameter int NCH = 16,
  parameter int SW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_strobe,
  input wire dds_pkg::dds_tgt_e target_sel,
  input wire logic [SW-1:0] slot_sel,
  input wire logic [N-1:0] phase_value,
  input wire logic [SW-1:0] rd_slot,
  output logic [N-1:0] step_q,
  output logic [N-1:0] shift_q
);
  import dds_pkg::*;

  logic [N-1:0] phase_step_value [NCH];
  logic [N-1:0] phase_shift_value [NCH];

  // ============================================================
  // stores: no clear and no run gate here on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        phase_step_value[i] <= '0;
        phase_shift_value[i] <= '0;
      end
    end else if (wr_strobe && (int'(slot_sel) < NCH)) begin
      if (target_sel == DDS_TGT_STEP) begin
        phase_step_value[slot_sel] <= phase_value;
      end else begin
        phase_shift_value[slot_sel] <= phase_value;
      end
    end
  end

  assign step_q = phase_step_value[rd_slot];
  assign shift_q = phase_shift_value[rd_slot];

  // ============================================================
  // checks
  step_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_strobe && target_sel == DDS_TGT_STEP && int'(slot_sel) < NCH
    |=> phase_step_value[$past(slot_sel)] == $past(phase_value))
    else $error("step store missed a write");
  shift_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_strobe && target_sel == DDS_TGT_SHIFT && int'(slot_sel) < NCH
    |=> phase_shift_value[$past(slot_sel)] == $past(phase_value))
    else $error("shift store missed a write");
  store_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_strobe |=> phase_step_value[$past(rd_slot)] == $past(step_q))
    else $error("step store changed without a write");
endmodule
`default_nettype wire

/* dds_sincos_lut.sv */
// coarse sine and cosine lookup from the top phase bits
`timescale 1ns/1ps
`default_nettype none
module dds_sincos_lut #(
  parameter int N = 32,
  parameter int P = 16
) (
  input wire logic [N-1:0] phase,
  output logic [P-1:0] sine,
  output logic [P-1:0] cosine
);
  import dds_pkg::*;

  // sixteen points a circle; no interpolation between them
  function automatic logic [15:0] sin16(input logic [3:0] idx);
    case (idx)
      4'h0: sin16 = 16'h0000;
      4'h1: sin16 = 16'h30FB;
      4'h2: sin16 = 16'h5A82;
      4'h3: sin16 = 16'h7641;
      4'h4: sin16 = 16'h7FFF;
      4'h5: sin16 = 16'h7641;
      4'h6: sin16 = 16'h5A82;
      4'h7: sin16 = 16'h30FB;
      4'h8: sin16 = 16'h0000;
      4'h9: sin16 = 16'hCF05;
      4'hA: sin16 = 16'hA57E;
      4'hB: sin16 = 16'h89BF;
      4'hC: sin16 = 16'h8001;
      4'hD: sin16 = 16'h89BF;
      4'hE: sin16 = 16'hA57E;
      default: sin16 = 16'hCF05;
    endcase
  endfunction

  logic [3:0] idx;
  logic [15:0] s16;
  logic [15:0] c16;

  // top bits only, so signed or unsigned phase lands on the same point
  assign idx = phase[N-1 -: 4];
  assign s16 = sin16(idx);
  assign c16 = sin16(idx + 4'h4);
  assign sine = s16[15 -: P];
  assign cosine = c16[15 -: P];
endmodule
`default_nettype wire

/* dds_ctrl.sv */
// synthesizer phase generator, control pins and apb configuration
//
// Added by the designer: the APB slave port and the register addresses.
`include "dds_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dds_ctrl #(
  parameter int N = 32,
  parameter int P = 16,
  parameter int NCH = 16,
  parameter int SW = (NCH <= 2) ? 1 : $clog2(NCH)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wr_strobe,
  input wire dds_pkg::dds_tgt_e target_sel,
  input wire logic [SW-1:0] slot_sel,
  input wire logic [N-1:0] phase_value,
  input wire logic run_gate,
  input wire logic sync_clear_input,
  input wire logic [N-1:0] phase_step_stream,
  input wire logic [N-1:0] phase_shift_stream,
  input wire logic [N-1:0] lut_phase_in,
  output logic out_valid,
  output logic [SW-1:0] out_chan,
  output logic [P-1:0] sine_out,
  output logic [P-1:0] cosine_out,
  output logic [N-1:0] phase_out
);
  import dds_pkg::*;

  // wraps at NCH-1, not at a power of two, so odd channel counts work
  function automatic logic [SW-1:0] next_slot(input logic [SW-1:0] s);
    if (int'(s) >= NCH - 1) begin
      next_slot = '0;
    end else begin
      next_slot = s + 1'b1;
    end
  endfunction

  // ============================================================
  // apb slave: zero wait states, read data caught at setup
  // the read word is frozen at the setup edge, so a status read shows the
  // output flags as they stood one cycle before the access completes
  // cfg and status are the only two words, decoded on paddr[11:0] alone; any other
  // low offset reports an error and writes to status are dropped
  logic [`DDS_CFG_W-1:0] cfg_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic setup;
  logic access;
  logic cfg_hit;
  logic stat_hit;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign cfg_hit = paddr[`DDS_ADDR_W-1:0] == `DDS_CFG_OFS;
  assign stat_hit = paddr[`DDS_ADDR_W-1:0] == `DDS_STAT_OFS;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  logic src_step_stream;
  logic src_shift_stream;
  logic lut_only;
  logic shift_en;
  assign src_step_stream = cfg_r[`DDS_CFG_STEP_SRC] == DDS_SRC_STREAM;
  assign src_shift_stream = cfg_r[`DDS_CFG_SHIFT_SRC] == DDS_SRC_STREAM;
  assign lut_only = cfg_r[`DDS_CFG_LUT_ONLY];
  assign shift_en = cfg_r[`DDS_CFG_SHIFT_EN];

  // writes to status or to an unmapped word leave cfg untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `DDS_CFG_RST;
    end else if (access && pwrite && cfg_hit) begin
      cfg_r <= pwdata[`DDS_CFG_W-1:0];
    end
  end

  // status is sampled live; a read sees the flags of its setup cycle
  logic [31:0] stat_word;
  always_comb begin
    stat_word = '0;
    stat_word[`DDS_STAT_VALID] = out_valid;
    stat_word[`DDS_STAT_CHAN_LSB +: SW] = out_chan;
  end

  // an unmapped address is flagged from setup until the next setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= !(cfg_hit || stat_hit);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup) begin
      if (cfg_hit) begin
        prdata_r <= {{(32-`DDS_CFG_W){1'b0}}, cfg_r};
      end else if (stat_hit) begin
        prdata_r <= stat_word;
      end else begin
        prdata_r <= '0;
      end
    end
  end

  // ============================================================
  // stores and their read port for the current channel
  logic [SW-1:0] ch_r;
  logic [N-1:0] step_q;
  logic [N-1:0] shift_q;

  dds_chan_store #(.N(N), .NCH(NCH), .SW(SW)) u_store (
    .pclk(pclk),
    .presetn(presetn),
    .wr_strobe(wr_strobe),
    .target_sel(target_sel),
    .slot_sel(slot_sel),
    .phase_value(phase_value),
    .rd_slot(ch_r),
    .step_q(step_q),
    .shift_q(shift_q)
  );

  // ============================================================
  // phase generator
  logic [N-1:0] acc_r [NCH];
  logic [N-1:0] step_cur;
  logic [N-1:0] shift_cur;
  logic [N-1:0] acc_nxt;
  logic [N-1:0] gen_phase;
  logic [N-1:0] stage_phase;
  logic run;
  logic gen_run;

  // a clear stops the pipe as well, so no stale sample slips out behind it
  assign run = run_gate && !sync_clear_input;
  assign gen_run = run && !lut_only;
  assign step_cur = src_step_stream ? phase_step_stream : step_q;
  assign shift_cur = src_shift_stream ? phase_shift_stream : shift_q;
  // plain N-bit wrap: the carry out is dropped by design
  assign acc_nxt = acc_r[ch_r] + step_cur;
  assign gen_phase = shift_en ? acc_r[ch_r] + shift_cur : acc_r[ch_r];
  assign stage_phase = lut_only ? lut_phase_in : gen_phase;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        acc_r[i] <= '0;
      end
    end else if (sync_clear_input) begin
      for (int i = 0; i < NCH; i++) begin
        acc_r[i] <= '0;
      end
    end else if (gen_run) begin
      acc_r[ch_r] <= acc_nxt;
    end
  end

  // the counter turns in lookup-only mode too, so out_chan stays meaningful
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_r <= '0;
    end else if (sync_clear_input) begin
      ch_r <= '0;
    end else if (run) begin
      ch_r <= next_slot(ch_r);
    end
  end

  // ============================================================
  // two-stage output pipeline
  logic [N-1:0] ph1_r;
  logic [SW-1:0] ch1_r;
  logic v1_r;
  logic [P-1:0] sine_c;
  logic [P-1:0] cosine_c;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph1_r <= '0;
      ch1_r <= '0;
    end else if (run) begin
      ph1_r <= stage_phase;
      ch1_r <= ch_r;
    end
  end

  // a clear drops validity at once rather than flushing the pipe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v1_r <= 1'b0;
      out_valid <= 1'b0;
    end else if (sync_clear_input) begin
      v1_r <= 1'b0;
      out_valid <= 1'b0;
    end else if (run) begin
      v1_r <= 1'b1;
      out_valid <= v1_r;
    end
  end

  // the table reads ph1_r, so phase_out and the samples stay aligned
  dds_sincos_lut #(.N(N), .P(P)) u_lut (
    .phase(ph1_r),
    .sine(sine_c),
    .cosine(cosine_c)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sine_out <= '0;
      cosine_out <= '0;
      phase_out <= '0;
      out_chan <= '0;
    end else if (run) begin
      sine_out <= sine_c;
      cosine_out <= cosine_c;
      phase_out <= ph1_r;
      out_chan <= ch1_r;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ============================================================
  // clear
  clear_chan_a: assert property (sync_clear_input |=> ch_r == '0)
    else $error("channel counter not cleared");
  clear_acc_a: assert property (sync_clear_input |=> acc_r[0] == '0)
    else $error("accumulator not cleared");
  clear_valid_a: assert property (sync_clear_input |=> !out_valid)
    else $error("valid survived a clear");

  // ============================================================
  // run gate and channel counter
  gate_hold_a: assert property (
    !run_gate && !sync_clear_input |=> $stable(ch_r) && $stable(out_valid))
    else $error("block advanced with run gate low");
  out_hold_a: assert property (
    !run |=> $stable(phase_out) && $stable(sine_out) && $stable(out_chan))
    else $error("outputs moved while the pipe was stopped");
  round_robin_a: assert property (
    run |=> ch_r == next_slot($past(ch_r)))
    else $error("channel counter skipped");
  chan_range_a: assert property (int'(ch_r) < NCH)
    else $error("channel counter left the configured range");

  // ============================================================
  // phase generator
  // expected phases come from the raw inputs one cycle back, not from the
  // datapath muxes, so a wrong select shows up here
  store_step_a: assert property (
    gen_run && !src_step_stream
    |=> acc_r[$past(ch_r)] == $past(acc_r[ch_r]) + $past(step_q))
    else $error("accumulator did not add the stored step");
  acc_step_a: assert property (
    gen_run && src_step_stream
    |=> acc_r[$past(ch_r)] == $past(acc_r[ch_r]) + $past(phase_step_stream))
    else $error("accumulator did not add the streamed step");
  shift_store_a: assert property (
    run && !lut_only && shift_en && !src_shift_stream
    |=> ph1_r == $past(acc_r[ch_r]) + $past(shift_q))
    else $error("stored shift not added to phase");
  shift_add_a: assert property (
    run && !lut_only && shift_en && src_shift_stream
    |=> ph1_r == $past(acc_r[ch_r]) + $past(phase_shift_stream))
    else $error("streamed shift not added to phase");
  lut_pass_a: assert property (
    run && lut_only |=> ph1_r == $past(lut_phase_in))
    else $error("lookup phase not passed through");

  // ============================================================
  // output valid and bus
  valid_rise_a: assert property (run [*2] |=> out_valid)
    else $error("valid missing after two run cycles");
  valid_cause_a: assert property (
    $rose(out_valid) |-> $past(v1_r) && $past(run))
    else $error("valid rose without a valid sample");
  apb_err_a: assert property (
    setup && !cfg_hit && !stat_hit |=> pslverr)
    else $error("unmapped address not flagged");

  // ============================================================
  // scenarios worth seeing
  stream_run_c: cover property ((src_step_stream && run) [*3]);
  clear_during_write_c: cover property (sync_clear_input && wr_strobe);
  channel_wrap_c: cover property (run && int'(ch_r) == NCH - 1);
  lut_only_c: cover property (lut_only && out_valid);
endmodule
`default_nettype wire

/* dds_user_model.sv */
// user-side model that drives the store write port of the synthesizer
`timescale 1ns/1ps
`default_nettype none
module dds_user_model #(
  parameter int N = 8,
  parameter int SW = 1
) (
  input wire logic pclk,
  output logic wr_strobe,
  output var dds_pkg::dds_tgt_e target_sel,
  output logic [SW-1:0] slot_sel,
  output logic [N-1:0] phase_value
);
  import dds_pkg::*;
  // ==========================================================
  // idle state
  initial begin
    wr_strobe = 1'b0;
    target_sel = DDS_TGT_STEP;
    slot_sel = '0;
    phase_value = '0;
  end
  // ==========================================================
  // one store write; a low-precision value goes to the top bits
  task automatic wr(input dds_tgt_e t, input logic [SW-1:0] s,
                    input logic [N-1:0] v, input int prec);
    @(posedge pclk);
    wr_strobe <= 1'b1;
    target_sel <= t;
    slot_sel <= s;
    phase_value <= v << (N - prec);
    @(posedge pclk);
    wr_strobe <= 1'b0;
    // released bus never shows the stale value
    phase_value <= ~(v << (N - prec));
  endtask
endmodule
`default_nettype wire

/* dds_ctrl_test.sv */
// self-checking bench for the synthesizer control block
`include "dds_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dds_ctrl_test;
  import dds_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, err, wr_strobe, out_valid, out_chan;
  dds_tgt_e target_sel;
  logic slot_sel, run_gate = 1'b0, sync_clear_input = 1'b0;
  logic [7:0] phase_value, phase_out, lut_phase_in = '0;
  logic [7:0] phase_step_stream = '0, phase_shift_stream = '0;
  logic [15:0] sine_out, cosine_out, cos0;
  int failures = 0, n_checks = 0, cyc = 0;
  localparam logic [31:0] CFG = {20'h0, `DDS_CFG_OFS};
  localparam logic [31:0] STAT = {20'h0, `DDS_STAT_OFS};
  dds_ctrl #(.N(8), .P(16), .NCH(2)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wr_strobe(wr_strobe), .target_sel(target_sel), .slot_sel(slot_sel),
    .phase_value(phase_value), .run_gate(run_gate),
    .sync_clear_input(sync_clear_input),
    .phase_step_stream(phase_step_stream),
    .phase_shift_stream(phase_shift_stream), .lut_phase_in(lut_phase_in),
    .out_valid(out_valid), .out_chan(out_chan), .sine_out(sine_out),
    .cosine_out(cosine_out), .phase_out(phase_out));
  dds_user_model #(.N(8), .SW(1)) u_user (.pclk(pclk),
    .wr_strobe(wr_strobe), .target_sel(target_sel), .slot_sel(slot_sel),
    .phase_value(phase_value));
  always #2 pclk = ~pclk;
  // ==========================================================
  // helpers
  task final_report;
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard well beyond the hundred or so cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      final_report;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task first_phase(input logic [7:0] e);
    // no local limit: a valid that never comes is caught by the hang guard
    do begin
      @(posedge pclk);
      #1;
    end while (out_valid !== 1'b1);
    chk(out_chan, 0);
    chk(phase_out, e);
  endtask
  // successive samples of one channel must differ by its step
  task diffs(input logic [7:0] s0, input logic [7:0] s1);
    logic [7:0] last [2];
    logic seen [2];
    logic [7:0] d;
    seen = '{1'b0, 1'b0};
    repeat (12) begin
      @(posedge pclk);
      #1;
      chk(out_valid, 1);
      if (seen[out_chan] === 1'b1) begin
        d = phase_out - last[out_chan];
        chk(d, out_chan ? s1 : s0);
      end
      last[out_chan] = phase_out;
      seen[out_chan] = 1'b1;
    end
  endtask
  task clear_pulse;
    @(posedge pclk);
    sync_clear_input <= 1'b1;
    @(posedge pclk);
    sync_clear_input <= 1'b0;
    #1;
    chk(out_valid, 0);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG, 32'h0);
    chk(rd, 32'h8);
    apb(1'b1, 32'h10, 32'hF);
    chk(err, 1);
    apb(1'b0, 32'h10, 32'h0);
    chk(err, 1);
    chk(rd, 32'h0);
    u_user.wr(DDS_TGT_STEP, 1'b0, 8'h20, 8);
    u_user.wr(DDS_TGT_STEP, 1'b1, 8'hE0, 8);
    u_user.wr(DDS_TGT_SHIFT, 1'b0, 8'h05, 3);
    @(posedge pclk);
    run_gate <= 1'b1;
    first_phase(8'hA0);
    diffs(8'h20, 8'hE0);
    // write lands while clear is high and the run gate is low
    @(posedge pclk);
    sync_clear_input <= 1'b1;
    run_gate <= 1'b0;
    u_user.wr(DDS_TGT_STEP, 1'b0, 8'h10, 8);
    @(posedge pclk);
    sync_clear_input <= 1'b0;
    run_gate <= 1'b1;
    #1;
    chk(out_valid, 0);
    first_phase(8'hA0);
    diffs(8'h10, 8'hE0);
    @(posedge pclk);
    phase_step_stream <= 8'h04;
    phase_shift_stream <= 8'h30;
    apb(1'b1, CFG, 32'hB);
    clear_pulse();
    first_phase(8'h30);
    diffs(8'h04, 8'h04);
    apb(1'b1, CFG, 32'hC);
    lut_phase_in <= 8'h00;
    repeat (4) @(posedge pclk);
    #1;
    chk(sine_out, 0);
    cos0 = cosine_out;
    @(posedge pclk);
    lut_phase_in <= 8'h40;
    repeat (4) @(posedge pclk);
    #1;
    chk(cosine_out, 0);
    chk(sine_out, cos0);
    apb(1'b0, STAT, 32'h0);
    chk(rd[0], 1);
    final_report;
  end
endmodule
`default_nettype wire
